// ---- dv/epsr_host_model.sv ----
// Host-side model of the two open-drain reset lines, each with a pull-up
`timescale 1ns/1ns
module epsr_host_model
(
   // Device drive and host pull requests, high means pull low
   input  wire logic rst_oe_in,
   input  wire logic mon_oe_in,
   input  wire logic rst_pull_in,
   input  wire logic mon_pull_in,
   // Resolved wire levels
   output logic      rst_lvl_out,
   output logic      mon_lvl_out
);
   // Released lines rise to the pull-up
   assign rst_lvl_out = !(rst_oe_in || rst_pull_in);
   assign mon_lvl_out = !(mon_oe_in || mon_pull_in);
endmodule : epsr_host_model

// ---- dv/epsr_supervisor_asserts.sv ----
// Concurrent checks on the supervisor ports
`timescale 1ns/1ns
module epsr_supervisor_chk
   import epsr_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk_in,
   input wire logic        rstn_in,
   // Watched ports
   input wire epsr_sense_t sense_in,
   input wire logic        rst_pin_oe_out,
   input wire logic        mon_pin_oe_out,
   input wire epsr_ctrl_t  ctrl_out,
   input wire logic        wake_clear_out,
   input wire logic        pd_count_inc_out,
   input wire epsr_state_t state_out
);
   // Sync, filter and output register, plus slack
   localparam int LAT = FILTER_CYC + 8;
   typedef struct packed {logic [15:0] act; logic [15:0] vov; logic [15:0] bov;} epsr_chk_t;
   epsr_chk_t cnt_q;  // Consecutive high cycles of the inputs
   epsr_chk_t cnt_d;
   // Counters saturate so a long key-on never wraps
   always_comb
   begin
      cnt_d = cnt_q;
      cnt_d.act = (sense_in.key | sense_in.wake_pin | sense_in.bus_wake | sense_in.eot_wake)
                  ? cnt_q.act + 16'(~&cnt_q.act) : 16'h0;
      cnt_d.vov = sense_in.v5_ov ? cnt_q.vov + 16'(~&cnt_q.vov) : 16'h0;
      cnt_d.bov = sense_in.bat_ov ? cnt_q.bov + 16'(~&cnt_q.bov) : 16'h0;
   end
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in) cnt_q <= '0;
      else          cnt_q <= cnt_d;
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // Leaving a state, in two steps
   sequence s_left_pdown;
      state_out == ST_PWRDOWN ##1 state_out != ST_PWRDOWN;
   endsequence
   sequence s_left_wclr;
      state_out == ST_WAKECLR ##1 state_out != ST_WAKECLR;
   endsequence
   a_pdown_exit: assert property (s_left_pdown |-> state_out == ST_WAKECLR)
      else $error("power-down left to a wrong state");
   a_wclr_flag: assert property ($rose(state_out == ST_WAKECLR) |-> ##[0:1] wake_clear_out)
      else $error("wake clear flag missing");
   a_wclr_exit: assert property (s_left_wclr |-> state_out inside {ST_SLEEP, ST_RAMP})
      else $error("wake clear left to a wrong state");
   a_wake_filter: assert property (state_out == ST_SLEEP && cnt_q.act < FILTER_CYC
      |=> state_out == ST_SLEEP) else $error("wake taken before filter time");
   a_arr_return: assert property (state_out == ST_AR_RESET |=> state_out == ST_NORMAL)
      else $error("afterrun reset not left at next edge");
   a_ramp_pins: assert property (state_out == ST_RAMP && $past(state_out) == ST_RAMP
      |-> rst_pin_oe_out && mon_pin_oe_out) else $error("reset pins released in ramp");
   a_v5ov_off: assert property (cnt_q.vov >= LAT && state_out == ST_NORMAL |->
      !ctrl_out.stages_en && !ctrl_out.comm_en && !ctrl_out.lin_can_en && rst_pin_oe_out
      && mon_pin_oe_out) else $error("overvoltage left functions on");
   a_batov_off: assert property (cnt_q.bov >= LAT |-> !ctrl_out.stages_en)
      else $error("battery overvoltage left stages on");
   a_pdinc_pulse: assert property (pd_count_inc_out |=> !pd_count_inc_out)
      else $error("power-down count step longer than one cycle");
endmodule : epsr_supervisor_chk
bind epsr_supervisor epsr_supervisor_chk chk_u (.*);

// ---- dv/epsr_tb.sv ----
// Self-checking bench for the power-state and reset supervisor
`timescale 1ns/1ns
module testbench
   import epsr_pkg::*;
;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} epsr_exp_t;
   logic        clk = 1'b0;       // 50 MHz
   logic        rstn = 1'b0;      // Power-on reset, active low
   epsr_sense_t sense = '0;       // Comparator levels
   logic        wd_inc = 1'b0, msc_to = 1'b0, pd_of = 1'b0;
   logic        rst_pull = 1'b0, mon_pull = 1'b0;
   logic        rst_lvl, mon_lvl, rst_oe, mon_oe, pd_inc, wclr;
   epsr_ctrl_t  ctrl;
   logic [27:0] stg;
   epsr_state_t st;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   epsr_exp_t   exp_q[$];         // Expected bus answers, oldest first
   epsr_exp_t   ex;
   int          error_cnt = 0, samples_checked = 0, pulses = 0, p0;
   logic        ar_seen = 1'b0;   // Afterrun reset state was visited
   integer      seed = 32'hBE01E1A6;
   logic [31:0] rnd;
   always #10 clk = ~clk;
   epsr_host_model host_u (.rst_oe_in(rst_oe), .mon_oe_in(mon_oe), .rst_pull_in(rst_pull),
      .mon_pull_in(mon_pull), .rst_lvl_out(rst_lvl), .mon_lvl_out(mon_lvl));
   epsr_supervisor dut_u (.ref_clk_in(clk), .rstn_in(rstn), .sense_in(sense),
      .wd_reset_inc_in(wd_inc), .msc_timeout_in(msc_to), .pd_counter_of_in(pd_of),
      .ssot_of_in(1'b0), .ramp_timer_of_in(1'b0), .rst_pin_in(rst_lvl),
      .rst_pin_oe_out(rst_oe), .rst_pin_out(), .mon_pin_in(mon_lvl), .mon_pin_oe_out(mon_oe),
      .mon_pin_out(), .ctrl_out(ctrl), .stage_en_out(stg), .wake_clear_out(wclr),
      .pd_count_inc_out(pd_inc), .state_out(st), .s_awaddr(awaddr), .s_awvalid(awvalid),
      .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
      .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
   // Single comparison point, four-state exact
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask : check
   task automatic finish_test();
      if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   // Bus write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back('{32'h0, 32'h0, r});
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr
   // Bus read, expected data compared under a mask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      exp_q.push_back('{d, m, r});
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : rd
   // Bounded wait for a state, a miss shows up as a mismatch
   task automatic wait_st(input epsr_state_t s, input int lim);
      for (int n = 0; st !== s && n < lim; n++) @(posedge clk);
      check(st, s);
   endtask : wait_st
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // Answer watcher: pops the oldest note for every accepted response
   always @(posedge clk)
   begin
      if (pd_inc === 1'b1) pulses++;
      if (st === ST_AR_RESET) ar_seen = 1'b1;
      if ((bvalid === 1'b1 && bready) || (rvalid === 1'b1 && rready))
      begin
         ex = exp_q.pop_front();
         check(bready ? bresp : rresp, ex.r);
         if (rready) check(rdata & ex.m, ex.d & ex.m);
      end
   end
   // Watchdog on the whole run
   initial
   begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial
   begin
      tick(6);
      rstn <= 1'b1;
      @(posedge clk);
      check(st, ST_SLEEP);
      rd(ADDR_CONFIG, CFG_RESET, 32'hFFFF_FFFF, RESP_OKAY);
      rd(8'h14, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(ADDR_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
      sense.eot_wake <= 1'b1; // Wake through one leg of the OR only
      tick(FILTER_CYC - 20);
      check(st, ST_SLEEP);
      wait_st(ST_RAMP, 100);
      wait_st(ST_NORMAL, 2 * FILTER_CYC);
      check(rst_oe, 32'h1);
      sense.key <= 1'b1;
      tick(FILTER_CYC + 20);
      sense.eot_wake <= 1'b0;
      tick(PUR_DELAY_CYC + FILTER_CYC);
      check(rst_oe, 32'h0);
      rd(ADDR_STATUS, 32'h0, 32'h1, RESP_OKAY);
      // Tracker faults must leave behaviour alone
      rnd = $random(seed);
      {sense.t1_uv, sense.t1_ov, sense.t2_uv, sense.t2_ov} <= rnd[3:0] | 4'h1;
      tick(FILTER_CYC + 20);
      check({st, rst_oe, mon_oe}, {ST_NORMAL, 2'b00});
      {sense.t1_uv, sense.t1_ov, sense.t2_uv, sense.t2_ov} <= 4'h0;
      rnd = $random(seed);
      wr(ADDR_STAGES, {4'h0, rnd[27:0]}, RESP_OKAY);
      mon_pull <= 1'b1;
      tick(8);
      mon_pull <= 1'b0;
      tick(4);
      rd(ADDR_STAGES, 32'h0, 32'h0FFF_FFFF, RESP_OKAY);
      wr(ADDR_STAGES, {4'h0, rnd[27:0]}, RESP_OKAY);
      msc_to <= 1'b1;
      @(posedge clk);
      msc_to <= 1'b0;
      tick(3);
      rd(ADDR_STAGES, 32'h0, 32'h0FFF_FFFF, RESP_OKAY);
      sense.bat_ov <= 1'b1;
      tick(FILTER_CYC + 10);
      check(ctrl.stages_en, 32'h0);
      sense.bat_ov <= 1'b0;
      sense.v5_ov <= 1'b1;
      tick(FILTER_CYC + 10);
      check({ctrl.stages_en, ctrl.comm_en, ctrl.lin_can_en, rst_oe, mon_oe}, 5'b00011);
      sense.v5_ov <= 1'b0;
      sense.v5_uv <= 1'b1;
      tick(FILTER_CYC + 10);
      check({rst_oe, mon_oe, ctrl.main_relay}, 3'b111);
      sense.v5_uv <= 1'b0;
      tick(PUR_DELAY_CYC + FILTER_CYC);
      wr(ADDR_CONFIG, 32'h1 << CFG_WDR_BIT, RESP_OKAY);
      wd_inc <= 1'b1;
      tick(4);
      check({rst_oe, ctrl.lin_can_rx, ctrl.stages_en}, 3'b110);
      wd_inc <= 1'b0;
      tick(PUR_DELAY_CYC + 50);
      p0 = pulses;
      wr(ADDR_CMD, CMD_SOFT_RESET, RESP_OKAY);
      tick(3);
      check(pulses - p0, 32'h1);
      rd(ADDR_CONFIG, CFG_RESET, 32'hFFFF_FFFF, RESP_OKAY);
      tick(PUR_DELAY_CYC + 50);
      wr(ADDR_CONFIG, 32'h1 << CFG_AE_BIT, RESP_OKAY);
      rst_pull <= 1'b1;
      tick(8);
      rst_pull <= 1'b0;
      tick(6);
      rd(ADDR_CONFIG, CFG_RESET, 32'hFFFF_FFFF, RESP_OKAY);
      // Afterrun with and without the reset on key re-entry
      wr(ADDR_CONFIG, (32'h1 << CFG_AE_BIT) | (32'h1 << CFG_AR_BIT), RESP_OKAY);
      sense.key <= 1'b0;
      wait_st(ST_AFTERRUN, FILTER_CYC + 50);
      rd(ADDR_STATUS, 32'h1, 32'h1, RESP_OKAY);
      sense.key <= 1'b1;
      wait_st(ST_AR_RESET, FILTER_CYC + 50);
      wait_st(ST_NORMAL, 2);
      wr(ADDR_CONFIG, 32'h1 << CFG_AE_BIT, RESP_OKAY);
      sense.key <= 1'b0;
      wait_st(ST_AFTERRUN, FILTER_CYC + 50);
      ar_seen = 1'b0;
      sense.key <= 1'b1;
      wait_st(ST_NORMAL, FILTER_CYC + 50);
      check(ar_seen, 32'h0);
      // Power-down with the shortest time select
      sense.key <= 1'b0;
      wait_st(ST_AFTERRUN, FILTER_CYC + 50);
      pd_of <= 1'b1;
      @(posedge clk);
      pd_of <= 1'b0;
      wait_st(ST_PWRDOWN, 10);
      tick(PDT_MS0 * CYC_PER_MS - 200);
      check(st, ST_PWRDOWN);
      wait_st(ST_WAKECLR, 400);
      @(posedge clk);
      check(wclr, 32'h1);
      wait_st(ST_SLEEP, FILTER_CYC + 50);
      // Second power-on reset with the key already high
      sense.key <= 1'b1;
      rstn <= 1'b0;
      tick(3);
      rstn <= 1'b1;
      wait_st(ST_RAMP, FILTER_CYC + 50);
      finish_test();
   end
endmodule : testbench

// ---- rtl/epsr_pkg.sv ----
// Package: register map, field layout, states, timing and carrier types for the supervisor
package epsr_pkg;

   // Register byte addresses (AXI4-Lite, one aligned word each)
   localparam logic [7:0] ADDR_CONFIG = 8'h00;   // operating_config_reg
   localparam logic [7:0] ADDR_STATUS = 8'h04;   // operating_status_reg
   localparam logic [7:0] ADDR_CMD    = 8'h08;   // software_reset_command
   localparam logic [7:0] ADDR_STAGES = 8'h0C;   // Stage enables, output 24 + ignition 4
   localparam logic [7:0] ADDR_DIAG   = 8'h10;   // Tracker diagnosis, write one to clear

   // Config field positions
   localparam int CFG_PDT_LSB = 0;               // powerdown_time_select, 2 bits
   localparam int CFG_AE_BIT  = 4;               // Afterrun enable
   localparam int CFG_AR_BIT  = 5;               // afterrun_reset_enable
   localparam int CFG_WDR_BIT = 6;               // watchdog_reset_enable
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // Command value that fires the software reset
   localparam logic [31:0] CMD_SOFT_RESET = 32'h0000_00A5;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing at 50 MHz
   localparam int CLK_HZ        = 50_000_000;
   localparam int FILTER_US     = 10;        // Input filter time
   localparam int PUR_DELAY_US  = 60;        // Power-up reset delay
   localparam int FILTER_CYC    = FILTER_US * (CLK_HZ / 1_000_000);
   localparam int PUR_DELAY_CYC = PUR_DELAY_US * (CLK_HZ / 1_000_000);
   // Power-down time per select code, in milliseconds
   localparam int PDT_MS0 = 1;
   localparam int PDT_MS1 = 2;
   localparam int PDT_MS2 = 4;
   localparam int PDT_MS3 = 8;
   localparam int CYC_PER_MS = CLK_HZ / 1000;

   // Operating states, Gray codes along sleep-ramp-normal-afterrun
   typedef enum logic [2:0] {
      ST_SLEEP    = 3'h0,
      ST_RAMP     = 3'h1,
      ST_NORMAL   = 3'h3,
      ST_AFTERRUN = 3'h2,
      ST_AR_RESET = 3'h6,
      ST_PWRDOWN  = 3'h7,
      ST_WAKECLR  = 3'h5
   } epsr_state_t;

   // Raw comparator and pin inputs
   typedef struct packed {
      logic key;           // Ignition key above threshold
      logic wake_pin;      // wake_input_pin level
      logic bus_wake;      // bus_transceiver_wake
      logic eot_wake;      // engine_off_timer_wake
      logic v5_uv;         // main_five_volt_supply undervoltage
      logic v5_ov;         // main_five_volt_supply overvoltage
      logic bat_ov;        // battery_supply overvoltage
      logic t1_uv;         // tracker_supply_one undervoltage
      logic t1_ov;
      logic t2_uv;         // tracker_supply_two undervoltage
      logic t2_ov;
   } epsr_sense_t;

   // Functional enables towards the rest of the chip
   typedef struct packed {
      logic supplies_en;   // 5 V regulators
      logic stages_en;     // Power stages
      logic comm_en;       // Serial channel and SPI
      logic lin_can_en;    // LIN and CAN transmit
      logic lin_can_rx;    // LIN and CAN receive only
      logic dso_active;    // Delayed switch-off active
      logic main_relay;    // Main relay on
   } epsr_ctrl_t;

endpackage : epsr_pkg

// ---- rtl/epsr_supervisor.sv ----
// Power-state and reset supervisor with AXI4-Lite register access
//
// Contract
// R1 - Power-down timer overflow enters wake clear
// R2 - Wake clear, key low: enter sleep
// R3 - Wake clear, key high: ramp up
// R4 - Wake is OR of three wakes
// R5 - Key, wake, supply inputs filtered first
// R6 - Status bit shows normal or afterrun
// R7 - Config field selects power-down time
// R8 - Internal power-on resets all, then sleep/ramp
// R9 - 5 V supplies off until power-on
// R10 - Power-on reset holds pins until delay
// R11 - 5 V undervoltage holds pins, delayed off
// R12 - Undervoltage: relay follows key, wake, battery
// R13 - Tracker faults only set diagnosis bits
// R14 - 5 V overvoltage disables external functions
// R15 - Battery overvoltage disables power stages
// R16 - Watchdog reset pulls reset, limits comms
// R17 - Software reset restores state, counts power-down
// R18 - External reset-pin low resets device
// R19 - Monitor-pin low clears stage enables
// R20 - Serial timeout clears stage enables
// R21 - Afterrun reset when enabled and key
// R22 - Afterrun reset returns next clock
// R23 - Key in afterrun, no reset: normal
// R24 - Comparator inputs synchronised before use
`timescale 1ns/1ns
module epsr_supervisor
   import epsr_pkg::*;
(
   // Clock and internal power-on reset
   input  wire logic         ref_clk_in,
   input  wire logic         rstn_in,        // see R8
   // Analog comparators and wake pins
   input  wire epsr_sense_t  sense_in,
   // Events from neighbouring blocks, same clock
   input  wire logic         wd_reset_inc_in,
   input  wire logic         msc_timeout_in,
   input  wire logic         pd_counter_of_in,
   input  wire logic         ssot_of_in,
   input  wire logic         ramp_timer_of_in,
   // Reset pins, open drain
   input  wire logic         rst_pin_in,
   output logic              rst_pin_oe_out,
   output logic              rst_pin_out,
   input  wire logic         mon_pin_in,
   output logic              mon_pin_oe_out,
   output logic              mon_pin_out,
   // Control to the rest of the chip
   output epsr_ctrl_t        ctrl_out,
   output logic [27:0]       stage_en_out,
   output logic              wake_clear_out,
   output logic              pd_count_inc_out,
   output epsr_state_t       state_out,
   // AXI4-Lite slave
   input  wire logic [7:0]   s_awaddr,
   input  wire logic         s_awvalid,
   output logic              s_awready,
   input  wire logic [31:0]  s_wdata,
   input  wire logic [3:0]   s_wstrb,
   input  wire logic         s_wvalid,
   output logic              s_wready,
   output logic [1:0]        s_bresp,
   output logic              s_bvalid,
   input  wire logic         s_bready,
   input  wire logic [7:0]   s_araddr,
   input  wire logic         s_arvalid,
   output logic              s_arready,
   output logic [31:0]       s_rdata,
   output logic [1:0]        s_rresp,
   output logic              s_rvalid,
   input  wire logic         s_rready
);

   localparam int NSENSE = $bits(epsr_sense_t);
   localparam int FW     = $clog2(FILTER_CYC + 1);

   // Whole module state
   typedef struct packed {
      epsr_sense_t  s1;          // First sync stage
      epsr_sense_t  s2;          // Second sync stage
      logic [1:0]   rst1;        // Pin-low sync, first stage [1]=rst [0]=mon
      logic [1:0]   rst2;
      epsr_sense_t  filt;        // Filtered levels
      logic [NSENSE*FW-1:0] fcnt;
      epsr_state_t  st;
      logic [31:0]  cfg;
      logic [27:0]  stages;
      logic [3:0]   diag;        // Tracker flags
      logic [31:0]  pdt_cnt;     // Power-down timer
      logic [31:0]  pur_cnt;     // Power-up reset delay
      logic         por_done;    // ECU power-on reset released
      logic         wd_hold;     // Watchdog reset active
      logic         aw_got;
      logic [7:0]   aw_addr;
      logic         w_got;
      logic [31:0]  w_data;
      logic [3:0]   w_strb;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
      logic         wclr;
      logic         pdinc;
      epsr_ctrl_t   ctrl;
      logic         rst_low;
      logic         mon_low;
      logic [1:0]   rst_hist;    // Own reset-pin drive, last two cycles
      logic [1:0]   mon_hist;    // Own monitor-pin drive, last two cycles
   } epsr_regs_t;

   epsr_regs_t q;   // Registered state
   epsr_regs_t d;   // Next state

   // Power-down duration in cycles for the selected code
   function automatic logic [31:0] pdt_cycles(input logic [1:0] sel);
      logic [31:0] ms;
      unique case (sel)
         2'h0: ms = 32'(PDT_MS0);
         2'h1: ms = 32'(PDT_MS1);
         2'h2: ms = 32'(PDT_MS2);
         2'h3: ms = 32'(PDT_MS3);
      endcase
      return 32'(ms * 32'(CYC_PER_MS));   // see R7
   endfunction : pdt_cycles

   // Next-state logic
   always_comb
   begin
      logic        wake;
      logic        key;
      logic        soft_rst;
      logic        ext_rst;
      logic        clr_stages;
      logic [FW-1:0] c;
      wake       = 1'b0;
      key        = 1'b0;
      soft_rst   = 1'b0;
      ext_rst    = 1'b0;
      clr_stages = 1'b0;
      c          = '0;
      d          = q;
      d.wclr     = 1'b0;
      d.pdinc    = 1'b0;

      // Two-stage synchronisers for comparators and pins
      d.s1   = sense_in;                      // see R24
      d.s2   = q.s1;
      // Stored inverted so the reset value 0 matches the idle high pins
      d.rst1 = ~{rst_pin_in, mon_pin_in};
      d.rst2 = q.rst1;
      // Our own drive reaches rst2 two cycles late, so remember it
      d.rst_hist = {q.rst_hist[0], q.rst_low};
      d.mon_hist = {q.mon_hist[0], q.mon_low};

      // Filters: level accepted after a stable run of FILTER_CYC cycles
      for (int i = 0; i < NSENSE; i++)
      begin
         c = q.fcnt[i*FW +: FW];
         if (q.s2[i] == q.filt[i])
         begin
            c = '0;
         end
         else if (c == FW'(FILTER_CYC - 1))
         begin
            d.filt[i] = q.s2[i];              // see R5
            c = '0;
         end
         else
         begin
            c = FW'(c + 1'b1);
         end
         d.fcnt[i*FW +: FW] = c;
      end

      wake = q.filt.wake_pin | q.filt.bus_wake | q.filt.eot_wake;   // see R4
      key  = q.filt.key;

      // AXI write: take address and data in either order
      if (s_awvalid && !q.aw_got)
      begin
         d.aw_got  = 1'b1;
         d.aw_addr = s_awaddr;
      end
      if (s_wvalid && !q.w_got)
      begin
         d.w_got  = 1'b1;
         d.w_data = s_wdata;
         d.w_strb = s_wstrb;
      end
      if (q.aw_got && q.w_got && !q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         unique case (q.aw_addr)
            ADDR_CONFIG:
            begin
               for (int b = 0; b < 4; b++)
               begin
                  if (q.w_strb[b])
                  begin
                     d.cfg[b*8 +: 8] = q.w_data[b*8 +: 8];
                  end
               end
            end
            ADDR_CMD:
            begin
               soft_rst = (q.w_data == CMD_SOFT_RESET);   // see R17
            end
            ADDR_STAGES:
            begin
               d.stages = q.w_data[27:0];
            end
            ADDR_DIAG:
            begin
               d.diag = q.diag & ~q.w_data[3:0];
            end
            ADDR_STATUS:
            begin
               d.bresp = RESP_OKAY;           // Read-only, write ignored
            end
            default:
            begin
               d.bresp = RESP_SLVERR;         // Unmapped
            end
         endcase
      end
      if (q.bvalid && s_bready)
      begin
         d.bvalid = 1'b0;
      end

      // AXI read
      if (s_arvalid && !q.rvalid)
      begin
         d.rvalid = 1'b1;
         d.rresp  = RESP_OKAY;
         unique case (s_araddr)
            ADDR_CONFIG: d.rdata = q.cfg;
            ADDR_STATUS: d.rdata = {26'h0, q.por_done,
                                    (q.st == ST_AFTERRUN), q.st,
                                    (q.st == ST_AFTERRUN)};   // see R6
            ADDR_CMD:    d.rdata = 32'h0000_0000;
            ADDR_STAGES: d.rdata = {4'h0, q.stages};
            ADDR_DIAG:   d.rdata = {28'h0, q.diag};
            default:
            begin
               d.rdata = 32'h0000_0000;
               d.rresp = RESP_SLVERR;
            end
         endcase
      end
      else if (q.rvalid && s_rready)
      begin
         d.rvalid = 1'b0;
      end

      // Tracker supplies only flag diagnosis, set wins over clear
      d.diag = d.diag | {q.filt.t2_ov, q.filt.t2_uv,
                         q.filt.t1_ov, q.filt.t1_uv};   // see R13

      // Monitor low or serial timeout drop all stage enables
      clr_stages = q.rst2[0] && !q.mon_low && (q.mon_hist == 2'b00);   // see R19
      if (clr_stages || msc_timeout_in)                 // see R20
      begin
         d.stages = '0;
      end

      // Externally forced reset-pin low while not driving it
      ext_rst = q.rst2[1] && !q.rst_low && (q.rst_hist == 2'b00);      // see R18

      // Watchdog reset held while its input stays high, set only when enabled
      if (wd_reset_inc_in && q.cfg[CFG_WDR_BIT])
      begin
         d.wd_hold = 1'b1;                              // see R16
      end
      else if (!wd_reset_inc_in)
      begin
         d.wd_hold = 1'b0;
      end

      // Operating state machine
      d.pdt_cnt = 32'h0;
      unique case (q.st)
         ST_SLEEP:
         begin
            if (key || wake) d.st = ST_RAMP;
         end
         ST_RAMP:
         begin
            if (!key && !wake) d.st = ST_SLEEP;
            else if (!key && ramp_timer_of_in) d.st = ST_WAKECLR;
            else if (!q.filt.v5_uv) d.st = ST_NORMAL;
         end
         ST_NORMAL:
         begin
            if ((pd_counter_of_in || ssot_of_in) && !key) d.st = ST_PWRDOWN;
            else if (!key && q.cfg[CFG_AE_BIT]) d.st = ST_AFTERRUN;
            else if (!key && !wake) d.st = ST_SLEEP;
         end
         ST_AFTERRUN:
         begin
            if (pd_counter_of_in || ssot_of_in) d.st = ST_PWRDOWN;
            else if (key && q.cfg[CFG_AR_BIT]) d.st = ST_AR_RESET;   // see R21
            else if (key) d.st = ST_NORMAL;                          // see R23
            else if (!q.cfg[CFG_AE_BIT] && !wake) d.st = ST_SLEEP;
         end
         ST_AR_RESET:
         begin
            d.st     = ST_NORMAL;                                    // see R22
            d.stages = '0;
         end
         ST_PWRDOWN:
         begin
            d.pdt_cnt = 32'(q.pdt_cnt + 1'b1);
            if (q.pdt_cnt >= pdt_cycles(q.cfg[CFG_PDT_LSB +: 2]) - 1)
            begin
               d.st   = ST_WAKECLR;                                  // see R1
               d.wclr = 1'b1;
            end
         end
         ST_WAKECLR:
         begin
            d.wclr = 1'b1;
            if (key) d.st = ST_RAMP;                                 // see R3
            else d.st = ST_SLEEP;                                    // see R2
         end
         default:
         begin
            d.st = ST_SLEEP;
         end
      endcase

      // ECU power-on reset: released after V5V is good for the delay
      if (q.st == ST_RAMP || q.st == ST_SLEEP || q.filt.v5_uv)
      begin
         d.pur_cnt  = 32'h0;
         d.por_done = 1'b0;
      end
      else if (!q.por_done)
      begin
         d.pur_cnt = 32'(q.pur_cnt + 1'b1);
         if (q.pur_cnt == 32'(PUR_DELAY_CYC - 1)) d.por_done = 1'b1;   // see R10
      end

      // Software or pin reset restores defaults
      if (soft_rst || ext_rst)
      begin
         d.cfg      = CFG_RESET;
         d.stages   = '0;
         d.por_done = 1'b0;
         d.pur_cnt  = 32'h0;
         d.pdinc    = soft_rst;                                      // see R17
      end

      // Reset and monitor pin drive
      d.mon_low = !q.por_done || (q.st == ST_RAMP) || q.filt.v5_uv
                  || q.filt.v5_ov;                                   // see R11
      d.rst_low = d.mon_low || q.wd_hold;

      // Functional enables
      d.ctrl.supplies_en = (q.st != ST_SLEEP);                       // see R9
      d.ctrl.stages_en   = q.por_done && !q.filt.v5_ov && !q.filt.bat_ov
                           && !q.wd_hold && !q.filt.v5_uv;           // see R15
      d.ctrl.comm_en     = q.por_done && !q.filt.v5_ov && !q.filt.v5_uv;   // see R14
      d.ctrl.lin_can_en  = d.ctrl.comm_en && !q.wd_hold;
      d.ctrl.lin_can_rx  = !q.filt.v5_ov;
      d.ctrl.dso_active  = q.filt.v5_uv || q.filt.v5_ov;
      d.ctrl.main_relay  = (key || wake) && !q.filt.bat_ov;          // see R12
   end

   // State register; internal power-on reset clears everything
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         q <= '0;                                                    // see R8
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs, all registered
   assign rst_pin_oe_out   = q.rst_low;
   assign rst_pin_out      = 1'b0;
   assign mon_pin_oe_out   = q.mon_low;
   assign mon_pin_out      = 1'b0;
   assign ctrl_out         = q.ctrl;
   assign stage_en_out     = q.stages;
   assign wake_clear_out   = q.wclr;
   assign pd_count_inc_out = q.pdinc;
   assign state_out        = q.st;
   assign s_awready        = !q.aw_got;
   assign s_wready         = !q.w_got;
   assign s_bvalid         = q.bvalid;
   assign s_bresp          = q.bresp;
   assign s_arready        = !q.rvalid;
   assign s_rvalid         = q.rvalid;
   assign s_rdata          = q.rdata;
   assign s_rresp          = q.rresp;

endmodule : epsr_supervisor
